// ### src/rtu_slave.sv
// Contract
// RULE1 - Write count high zero, low 1 to 123.
// RULE2 - Byte count is twice count, values high first.
// RULE3 - Write success echoes address, function, start, count.
// RULE4 - Write failure answers 0x90 with code 04.
// RULE5 - Write codes: 01 function, 02 range, 03 count.
// RULE6 - Read request: address, 0x04, start, count, checksum.
// RULE7 - Read reply: byte count, registers high first.
// RULE8 - Read failure answers 0x84 with 01, 03, 04.
// RULE9 - Range beyond register space gives code 02.
// RULE10 - Checksum generator constant is 0xA001.
// RULE11 - Checksum preset to all ones per frame.
// RULE12 - Checksum starts at address byte, transmission order.
// RULE13 - Shift right, XOR generator if bit out.
// RULE14 - Exactly eight steps per byte.
// RULE15 - All bytes before checksum field are covered.
// RULE16 - Checksum appended low byte first.
// RULE17 - Frames delimited by 3.5 character silence.
// RULE18 - Accept broadcast zero and own address.
// RULE19 - Bad checksum frame is dropped silently.
// RULE20 - No reply to broadcast or foreign address.
module rtu_slave #(
  parameter int unsigned GAP_CYCLES = int'(rtu_pkg::GAP_CYC_DEF), // Idle cycles that end a frame.
  parameter int unsigned HOLD_REGS  = 16,                         // Holding registers present.
  parameter int unsigned INPUT_REGS = 16,                         // Input registers present.
  parameter int unsigned RD_MAX     = 125                         // Largest read count served.
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic [7:0]  OWN_ADDR,
  input  wire logic        RX_VALID,
  input  wire logic [7:0]  RX_DATA,
  output logic             TX_VALID,
  output logic [7:0]       TX_DATA,
  input  wire logic        TX_READY,
  output logic             WR_STB,
  output logic [15:0]      WR_ADDR,
  output logic [15:0]      WR_DATA,
  input  wire logic        WR_FAIL,
  output logic             RD_STB,
  output logic [15:0]      RD_ADDR,
  input  wire logic [15:0] RD_DATA,
  input  wire logic        RD_FAIL
);
  import rtu_pkg::*;

  // A read reply must fit the frame store together with header and checksum.
  if (GAP_CYCLES < 1 || RD_MAX < 1 || RD_MAX > 125 || HOLD_REGS > 65536 || INPUT_REGS > 65536)
  begin : g_bad_param
    $error("rtu_slave parameter out of range");
  end

  // The whole state of the handler. The frame store holds the request and is
  // reused in place for the reply, which saves a second 256-byte array.
  typedef struct packed {
    state_e            st;    // Current phase.
    logic [255:0][7:0] mem;   // Frame store.
    logic [8:0]        len;   // Bytes received in this frame.
    logic              ovf;   // More bytes than the store holds.
    logic [31:0]       sil;   // Idle cycles since the last received byte.
    logic [15:0]       crc;   // Running checksum.
    logic [15:0]       crc1;  // Checksum before the last byte.
    logic [15:0]       crc2;  // Checksum before the last two bytes.
    logic [8:0]        idx;   // Checksum or transmit position.
    logic [8:0]        rlen;  // Reply length.
    logic [15:0]       cur;   // Register address being accessed.
    logic [15:0]       cnt;   // Requested register count.
    logic [7:0]        ptr;   // Registers done so far.
    logic              bcast; // Frame was a broadcast.
    logic [7:0]        txd;   // Byte offered on the transmit port.
    logic [15:0]       wd;    // Value offered on the write port.
  } state_s;

  state_s q;  // Registered state.
  state_s d;  // Next state.

  // Request fields, decoded once from the store.
  logic [7:0]  fc;
  logic [15:0] req_start;
  logic [15:0] req_cnt;
  logic [16:0] req_end;
  logic [15:0] crc_rx;
  logic        frame_ok;
  logic        wr_cnt_ok;
  logic        rd_cnt_ok;

  // One byte of checksum: fold the byte in, then eight shift steps.
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {8'h00, b};                                    // see RULE12
    for (int i = 0; i < 8; i++)                            // see RULE14
    begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);         // see RULE10 see RULE13
    end
    return v;
  endfunction

  assign fc        = q.mem[POS_FC];
  assign req_start = {q.mem[POS_START_HI], q.mem[POS_START_LO]};
  assign req_cnt   = {q.mem[POS_CNT_HI], q.mem[POS_CNT_LO]};
  assign req_end   = {1'b0, req_start} + {1'b0, req_cnt};
  // The received checksum sits in the last two bytes, low byte first.
  assign crc_rx    = {q.mem[8'(q.len - 9'h001)], q.mem[8'(q.len - 9'h002)]};  // see RULE16

  // A frame is served only if it is whole, its checksum matches and it is ours.
  assign frame_ok = !q.ovf && q.len >= READ_REQ_LEN
                 && q.crc2 == crc_rx                                   // see RULE15 see RULE19
                 && (q.mem[POS_ADDR] == ADDR_BCAST                      // see RULE18
                     || (q.mem[POS_ADDR] == OWN_ADDR && OWN_ADDR <= ADDR_MAX));

  // Count and byte count of a write; the frame length must agree with both.
  assign wr_cnt_ok = q.mem[POS_CNT_HI] == 8'h00                          // see RULE1
                  && q.mem[POS_CNT_LO] >= WR_CNT_MIN && q.mem[POS_CNT_LO] <= WR_CNT_MAX
                  && q.mem[POS_BYTES] == {q.mem[POS_CNT_LO][6:0], 1'b0}  // see RULE2
                  && q.len == WR_HDR_LEN + {1'b0, q.mem[POS_BYTES]} + CRC_LEN;

  // A read request has a fixed length and a bounded count.
  assign rd_cnt_ok = q.len == READ_REQ_LEN                               // see RULE6
                  && req_cnt >= 16'h0001 && req_cnt <= 16'(RD_MAX);

  // Next-state logic for every phase of the frame.
  always_comb
  begin
    logic       raise;   // Answer with an exception.
    logic [7:0] code;    // Exception code to send.
    logic       finish;  // Reply body complete.
    logic       restart; // Return to listening with a fresh frame.
    raise   = 1'b0;
    code    = 8'h00;
    finish  = 1'b0;
    restart = 1'b0;
    d       = q;
    unique case (q.st)
      ST_RX:
      begin
        if (RX_VALID)
        begin
          // Bytes past the store are counted as overflow and spoil the frame.
          if (q.len < BUF_DEPTH)
          begin
            d.mem[q.len[7:0]] = RX_DATA;
            d.len             = q.len + 9'h001;
          end
          else
          begin
            d.ovf = 1'b1;
          end
          d.crc2 = q.crc1;
          d.crc1 = q.crc;
          d.crc  = crc_byte(q.crc, RX_DATA);                   // see RULE15
          d.sil  = 32'h0000_0000;
        end
        else if (q.len != 9'h000)
        begin
          // Silence after the last byte closes the frame.
          d.sil = q.sil + 32'h0000_0001;
          if (q.sil >= 32'(GAP_CYCLES - 1))                    // see RULE17
          begin
            d.st = ST_CHK;
          end
        end
      end
      ST_CHK:
      begin
        d.cur   = req_start;
        d.cnt   = req_cnt;
        d.ptr   = 8'h00;
        d.bcast = q.mem[POS_ADDR] == ADDR_BCAST;
        if (!frame_ok)
        begin
          restart = 1'b1;                                      // see RULE19
        end
        else if (fc == FC_WRITE_MULTI)
        begin
          // Count errors take priority over range errors.
          if (!wr_cnt_ok)
          begin
            raise = 1'b1;
            code  = ERR_COUNT;                                 // see RULE5
          end
          else if (req_end > 17'(HOLD_REGS))
          begin
            raise = 1'b1;
            code  = ERR_ADDR;                                  // see RULE9
          end
          else
          begin
            d.st = ST_WR;
          end
        end
        else if (fc == FC_READ_INPUT)
        begin
          if (!rd_cnt_ok)
          begin
            raise = 1'b1;
            code  = ERR_COUNT;                                 // see RULE8
          end
          else if (req_end > 17'(INPUT_REGS))
          begin
            raise = 1'b1;
            code  = ERR_ADDR;                                  // see RULE9
          end
          else
          begin
            d.mem[POS_BYTES - 8'h04] = {req_cnt[6:0], 1'b0};   // see RULE7
            d.rlen                   = RD_HDR_LEN;
            d.st                     = ST_RD;
          end
        end
        else
        begin
          raise = 1'b1;
          code  = ERR_FUNC;                                    // see RULE5 see RULE8
        end
      end
      ST_WR:
      begin
        // One register per cycle; a refusal stops the sequence.
        if (WR_FAIL)
        begin
          raise = 1'b1;
          code  = ERR_DEVICE;                                  // see RULE4
        end
        else
        begin
          d.cur = q.cur + 16'h0001;
          d.ptr = q.ptr + 8'h01;
          if (q.ptr == q.cnt[7:0] - 8'h01)
          begin
            // The first six request bytes are already the echo reply.
            d.rlen = ECHO_LEN;                                 // see RULE3
            finish = 1'b1;
          end
        end
      end
      ST_RD:
      begin
        if (RD_FAIL)
        begin
          raise = 1'b1;
          code  = ERR_DEVICE;                                  // see RULE8
        end
        else
        begin
          d.mem[q.rlen[7:0]]          = RD_DATA[15:8];         // see RULE7
          d.mem[8'(q.rlen + 9'h001)] = RD_DATA[7:0];
          d.rlen                      = q.rlen + 9'h002;
          d.cur                       = q.cur + 16'h0001;
          d.ptr                       = q.ptr + 8'h01;
          finish                      = q.ptr == q.cnt[7:0] - 8'h01;
        end
      end
      ST_CRC:
      begin
        if (q.idx < q.rlen)
        begin
          d.crc = crc_byte(q.crc, q.mem[q.idx[7:0]]);          // see RULE15
          d.idx = q.idx + 9'h001;
        end
        else
        begin
          d.mem[q.rlen[7:0]]          = q.crc[7:0];            // see RULE16
          d.mem[8'(q.rlen + 9'h001)] = q.crc[15:8];
          d.rlen                      = q.rlen + CRC_LEN;
          d.idx                       = 9'h000;
          d.st                        = ST_TX;
        end
      end
      ST_TX:
      begin
        if (TX_READY)
        begin
          if (q.idx == q.rlen - 9'h001)
          begin
            restart = 1'b1;
          end
          else
          begin
            d.idx = q.idx + 9'h001;
          end
        end
      end
      default:
      begin
        restart = 1'b1;
      end
    endcase
    // Exception reply: flagged function code and one code byte.
    if (raise)
    begin
      d.mem[POS_FC]  = q.mem[POS_FC] | EXC_FLAG;               // see RULE4 see RULE8
      d.mem[POS_ERR] = code;
      d.rlen         = EXC_LEN;
      finish         = 1'b1;
    end
    // Broadcasts still perform their writes but never answer.
    if (finish)
    begin
      if (d.bcast)
      begin
        restart = 1'b1;                                        // see RULE20
      end
      else
      begin
        d.st  = ST_CRC;
        d.idx = 9'h000;
        d.crc = CRC_INIT;                                      // see RULE11
      end
    end
    if (restart)
    begin
      d.st  = ST_RX;
      d.len = 9'h000;
      d.ovf = 1'b0;
      d.sil = 32'h0000_0000;
      d.crc = CRC_INIT;                                        // see RULE11 see RULE12
    end
    // Port data follows the next position so that it comes from flip-flops.
    d.txd = d.mem[d.idx[7:0]];
    d.wd  = {d.mem[POS_WDATA + {d.ptr[6:0], 1'b0}],            // see RULE2
             d.mem[POS_WDATA + {d.ptr[6:0], 1'b1}]};
  end

  // State register with synchronous reset.
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      q     <= '0;
      q.st  <= ST_RX;
      q.crc <= CRC_INIT;
    end
    else
    begin
      q <= d;
    end
  end

  assign TX_VALID = q.st == ST_TX;
  assign TX_DATA  = q.txd;
  assign WR_STB   = q.st == ST_WR;
  assign WR_ADDR  = q.cur;
  assign WR_DATA  = q.wd;
  assign RD_STB   = q.st == ST_RD;
  assign RD_ADDR  = q.cur;

endmodule

// ### src/rtu_pkg.sv
package rtu_pkg;

  // Function codes handled by this slave, and the flag that marks an exception reply.
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FC_READ_INPUT  = 8'h04;
  localparam logic [7:0] EXC_FLAG       = 8'h80;

  // Exception codes carried in the byte after the flagged function code.
  localparam logic [7:0] ERR_FUNC   = 8'h01;
  localparam logic [7:0] ERR_ADDR   = 8'h02;
  localparam logic [7:0] ERR_COUNT  = 8'h03;
  localparam logic [7:0] ERR_DEVICE = 8'h04;

  // Slave addressing: zero is broadcast, targeted addresses run up to this value.
  localparam logic [7:0] ADDR_BCAST = 8'h00;
  localparam logic [7:0] ADDR_MAX   = 8'hF7;

  // Register count limits of a write-multiple request.
  localparam logic [7:0] WR_CNT_MIN = 8'h01;
  localparam logic [7:0] WR_CNT_MAX = 8'h7B;

  // Checksum generator and preset.
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;

  // Byte positions inside a frame and fixed frame lengths.
  localparam logic [7:0] POS_ADDR     = 8'h00;
  localparam logic [7:0] POS_FC       = 8'h01;
  localparam logic [7:0] POS_START_HI = 8'h02;
  localparam logic [7:0] POS_START_LO = 8'h03;
  localparam logic [7:0] POS_CNT_HI   = 8'h04;
  localparam logic [7:0] POS_CNT_LO   = 8'h05;
  localparam logic [7:0] POS_BYTES    = 8'h06;
  localparam logic [7:0] POS_ERR      = 8'h02;
  localparam logic [7:0] POS_WDATA    = 8'h07;
  localparam logic [8:0] READ_REQ_LEN = 9'h008;
  localparam logic [8:0] WR_HDR_LEN   = 9'h007;
  localparam logic [8:0] CRC_LEN      = 9'h002;
  localparam logic [8:0] ECHO_LEN     = 9'h006;
  localparam logic [8:0] EXC_LEN      = 9'h003;
  localparam logic [8:0] RD_HDR_LEN   = 9'h003;
  localparam logic [8:0] BUF_DEPTH    = 9'h100;

  // Frame gap: 3.5 character times of 11 bits each at the link rate.
  localparam longint CLK_HZ      = 50_000_000;
  localparam longint BAUD_DEF    = 9600;
  localparam longint CHAR_BITS   = 11;
  localparam longint GAP_TENTHS  = 35;
  localparam longint GAP_CYC_DEF =
    (GAP_TENTHS * CHAR_BITS * CLK_HZ + 10 * BAUD_DEF - 1) / (10 * BAUD_DEF);

  // Frame handler states, one-hot.
  typedef enum logic [5:0] {
    ST_RX  = 6'h01,
    ST_CHK = 6'h02,
    ST_WR  = 6'h04,
    ST_RD  = 6'h08,
    ST_CRC = 6'h10,
    ST_TX  = 6'h20
  } state_e;

endpackage

// ### verif/rtu_slave_properties.sv
module rtu_slave_properties #(
  parameter int unsigned GAP = 20 // Idle cycles that close a request frame.
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        RX_VALID,
  input wire logic        TX_VALID,
  input wire logic [7:0]  TX_DATA,
  input wire logic        TX_READY,
  input wire logic        WR_STB,
  input wire logic [15:0] WR_ADDR,
  input wire logic        WR_FAIL,
  input wire logic        RD_STB,
  input wire logic [15:0] RD_ADDR,
  input wire logic        RD_FAIL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] idle_q; // Cycles since the last received byte, saturating.
  // Counts the silence on the receive side so the full gap can be checked,
  // not just its first few cycles.
  always_ff @(posedge CLK)
  begin
    if (!RST_N || RX_VALID)
    begin
      idle_q <= 32'h0000_0000;
    end
    else if (idle_q != 32'hFFFF_FFFF)
    begin
      idle_q <= idle_q + 32'h0000_0001;
    end
  end
  // One clock domain, so clock and reset are given once for all checks.
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Nothing is driven on the first edge out of reset.
  property p_rst;
    $rose(RST_N) |-> !TX_VALID && !WR_STB && !RD_STB;
  endproperty
  a_rst: assert property (p_rst) else $error("output active after reset");
  // A burst of writes walks up the register space one word at a time.
  property p_wr_seq;
    WR_STB && $past(WR_STB) |-> WR_ADDR == $past(WR_ADDR) + 16'h0001;
  endproperty
  a_wr_seq: assert property (p_wr_seq) else $error("write address skipped");
  property p_rd_seq;
    RD_STB && $past(RD_STB) |-> RD_ADDR == $past(RD_ADDR) + 16'h0001;
  endproperty
  a_rd_seq: assert property (p_rd_seq) else $error("read address skipped");
  // A frame is either a write or a read, never both.
  property p_excl;
    !(WR_STB && RD_STB);
  endproperty
  a_excl: assert property (p_excl) else $error("write and read together");
  // A stalled reply byte stays put until it is taken.
  property p_tx_hold;
    TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("reply byte changed");
  // A refused access ends the burst at once.
  property p_wr_stop;
    WR_STB && WR_FAIL |=> !WR_STB [*4];
  endproperty
  a_wr_stop: assert property (p_wr_stop) else $error("write went on");
  property p_rd_stop;
    RD_STB && RD_FAIL |=> !RD_STB [*4];
  endproperty
  a_rd_stop: assert property (p_rd_stop) else $error("read went on");
  // The reply stays off for the first eight cycles after each received byte.
  property p_gap;
    RX_VALID |=> !TX_VALID [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("reply inside gap");
  // A reply may only start once the whole frame gap has passed in silence.
  property p_gap_full;
    $rose(TX_VALID) |-> idle_q >= GAP;
  endproperty
  a_gap_full: assert property (p_gap_full) else $error("reply before full gap");
  // The reply comes only after all writes are done.
  property p_quiet;
    WR_STB |-> !TX_VALID;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reply during writes");
  c_wr: cover property (WR_STB ##1 WR_STB);
  c_rd: cover property (RD_STB && RD_FAIL);
  c_tx: cover property (TX_VALID && !TX_READY ##1 TX_VALID && TX_READY);
endmodule

// ### verif/rtu_host.sv
module rtu_host (
  input  wire logic       clk,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       slow = 1'b0; // Spaces request bytes and stalls the reply when set.
  logic [7:0] got[$];      // Reply bytes taken so far.
  // Frame checksum over a byte list.
  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] v;
    v = 16'hFFFF;
    foreach (q[i])
    begin
      v = v ^ {8'h00, q[i]};
      repeat (8) v = v[0] ? (v >> 1) ^ 16'hA001 : v >> 1;
    end
    return v;
  endfunction
  // Sends a frame; bad spoils the checksum. An idle line shows the inverse byte.
  task automatic send(input logic [7:0] q[$], input logic bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data <= q[i];
      if (slow)
      begin
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data <= ~q[i];
      end
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data <= ~q[q.size() - 1];
  endtask
  // Sampled mid-cycle, so the byte is the one taken at the next edge.
  always @(negedge clk)
    if (tx_valid && tx_ready)
      got.push_back(tx_data);
  // When slow, ready drops every other cycle.
  always @(posedge clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;
endmodule

// ### verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] bytes_t[$];
  localparam logic [7:0] own = 8'h11; // Address of the slave under test.
  localparam int gap = 20;            // Frame gap in cycles, short to keep the run brief.
  logic        clk = 1'b0;
  logic        rst_n, rx_valid, tx_valid, tx_ready, wr_stb, wr_fail, rd_stb, rd_fail;
  logic [7:0]  own_addr, rx_data, tx_data;
  logic [15:0] wr_addr, wr_data, rd_addr, rd_data;
  logic [15:0] wa[$], wd[$]; // Writes seen at the register port.
  bytes_t      none;         // Stays empty: no reply expected.
  int          num_errors = 0;
  int          comparisons = 0;
  always #10 clk = ~clk;
  // Input registers read as their address with a fixed pattern folded in.
  assign rd_data = rd_addr ^ 16'hC35A;
  rtu_host host_u (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  // A short gap keeps the run brief.
  rtu_slave #(.GAP_CYCLES(gap)) dut_u (.CLK(clk), .RST_N(rst_n), .OWN_ADDR(own_addr),
    .RX_VALID(rx_valid), .RX_DATA(rx_data), .TX_VALID(tx_valid), .TX_DATA(tx_data),
    .TX_READY(tx_ready), .WR_STB(wr_stb), .WR_ADDR(wr_addr), .WR_DATA(wr_data),
    .WR_FAIL(wr_fail), .RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_DATA(rd_data),
    .RD_FAIL(rd_fail));
  always @(negedge clk)
    if (wr_stb)
    begin
      wa.push_back(wr_addr);
      wd.push_back(wr_data);
    end
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic bytes_t fr(input logic [7:0] a, fc, input logic [15:0] s, n);
    bytes_t q;
    q = {a, fc, s[15:8], s[7:0], n[15:8], n[7:0]};
    return q;
  endfunction
  function automatic bytes_t crcd(input bytes_t q);
    logic [15:0] c;
    c = host_u.crc16(q);
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    return q;
  endfunction
  function automatic bytes_t exc(input logic [7:0] fc, code);
    bytes_t q;
    q = {own, fc | 8'h80, code};
    return crcd(q);
  endfunction
  function automatic bytes_t wreq(input logic [7:0] a, input logic [15:0] s, n,
                                  input logic [7:0] bc);
    bytes_t q;
    q = fr(a, 8'h10, s, n);
    q.push_back(bc);
    for (int i = 0; i < bc; i++)
      q.push_back(8'hA0 ^ 8'(i));
    return q;
  endfunction
  // Sends a frame, then leaves a silent gap while the reply is gathered.
  task automatic xact(input bytes_t req, exp, input logic bad);
    int i;
    host_u.got.delete();
    wa.delete();
    wd.delete();
    // The host keeps the frame gap after the previous reply before it talks again.
    repeat (gap) @(posedge clk);
    host_u.send(req, bad);
    for (i = 0; i < 1000; i++)
    begin
      @(negedge clk);
      if (exp.size() != 0 && host_u.got.size() == exp.size() && !tx_valid)
        break;
    end
    if (exp.size() != 0 && i == 1000)
    begin
      num_errors++;
      results();
    end
    check(16'(host_u.got.size()), 16'(exp.size()));
    foreach (exp[k])
      check({8'h00, host_u.got[k]}, {8'h00, exp[k]});
    @(posedge clk);
  endtask
  // Writes at the top of the range with a stalling host, then a broadcast.
  task automatic t_write;
    host_u.slow <= 1'b1;
    xact(wreq(own, 16'h000E, 16'h0002, 8'h04), crcd(fr(own, 8'h10, 16'h000E, 16'h0002)), 1'b0);
    check(16'(wa.size()), 16'h0002);
    foreach (wa[k])
    begin
      check(wa[k], 16'h000E + 16'(k));
      check(wd[k], {8'hA0 ^ 8'(2 * k), 8'hA1 ^ 8'(2 * k)});
    end
    host_u.slow <= 1'b0;
    xact(wreq(8'h00, 16'h0004, 16'h0002, 8'h04), none, 1'b0);
    check(16'(wa.size()), 16'h0002);
  endtask
  // Bad counts, byte counts and ranges, then a refused write.
  task automatic t_werr;
    logic [15:0] s[5] = '{16'h0000, 16'h0000, 16'h000F, 16'h0000, 16'h0000};
    logic [15:0] n[5] = '{16'h0000, 16'h0001, 16'h0002, 16'h007B, 16'h0101};
    logic [7:0]  bc[5] = '{8'h00, 8'h04, 8'h04, 8'hF6, 8'h02};
    logic [7:0]  e[5] = '{8'h03, 8'h03, 8'h02, 8'h02, 8'h03};
    for (int i = 0; i < 5; i++)
    begin
      xact(wreq(own, s[i], n[i], bc[i]), exc(8'h10, e[i]), 1'b0);
      check(16'(wa.size()), 16'h0000);
    end
    wr_fail <= 1'b1;
    xact(wreq(own, 16'h0000, 16'h0003, 8'h06), exc(8'h10, 8'h04), 1'b0);
    check(16'(wa.size()), 16'h0001);
    wr_fail <= 1'b0;
  endtask
  // A good read, each error code, and a broadcast read.
  task automatic t_read;
    logic [7:0]  f[5] = '{8'h04, 8'h04, 8'h04, 8'h03, 8'h06};
    logic [15:0] s[5] = '{16'h0000, 16'h0000, 16'h000F, 16'h0000, 16'h0000};
    logic [15:0] n[5] = '{16'h0000, 16'h007E, 16'h0002, 16'h0001, 16'h0001};
    logic [7:0]  e[5] = '{8'h03, 8'h03, 8'h02, 8'h01, 8'h01};
    bytes_t      r;
    r = {own, 8'h04, 8'h04, 8'hC3, 8'h54, 8'hC3, 8'h55};
    xact(fr(own, 8'h04, 16'h000E, 16'h0002), crcd(r), 1'b0);
    for (int i = 0; i < 5; i++)
      xact(fr(own, f[i], s[i], n[i]), exc(f[i], e[i]), 1'b0);
    rd_fail <= 1'b1;
    xact(fr(own, 8'h04, 16'h0000, 16'h0002), exc(8'h04, 8'h04), 1'b0);
    rd_fail <= 1'b0;
    xact(fr(8'h00, 8'h04, 16'h0000, 16'h0001), none, 1'b0);
  endtask
  // Spoiled checksum and a foreign address draw no reply.
  task automatic t_drop;
    xact(fr(own, 8'h04, 16'h0000, 16'h0001), none, 1'b1);
    xact(fr(8'h12, 8'h04, 16'h0000, 16'h0001), none, 1'b0);
  endtask
  initial
  begin
    rst_n = 1'b0;
    host_u.rx_valid = 1'b0;
    host_u.rx_data = 8'h00;
    own_addr = own;
    wr_fail = 1'b0;
    rd_fail = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_write();
    t_werr();
    t_read();
    t_drop();
    results();
  end
endmodule
bind rtu_slave rtu_slave_properties #(.GAP(GAP_CYCLES)) chk_u (.CLK(CLK), .RST_N(RST_N),
  .RX_VALID(RX_VALID), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_READY(TX_READY),
  .WR_STB(WR_STB), .WR_ADDR(WR_ADDR), .WR_FAIL(WR_FAIL), .RD_STB(RD_STB),
  .RD_ADDR(RD_ADDR), .RD_FAIL(RD_FAIL));
